// ---- design/dop_ctrl.sv ----
/*
  decoder output port control: register bank over AHB-Lite, reference signal selection,
  output byte formatting and a FIFO in front of the 8-bit port.
  assumes hclk is the line-locked pixel clock and the video inputs are synchronous to it.
*/
`timescale 1ns/1ps

module dop_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH):0]          count
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } dop_fifo_st_s;
  dop_fifo_st_s s, n;

  // depth must be a power of two so the pointer wrap bit stays honest
  assign count     = s.wp - s.rp;
  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = s.mem[s.rp[AW-1:0]];

  always_comb begin
    n = s;
    if (in_valid && in_ready) begin
      n.mem[s.wp[AW-1:0]] = in_data;
      n.wp = s.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      n.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule // dop_fifo

module dop_ctrl #(
  parameter int unsigned FIFO_W = dop_pkg::FIFO_WIDTH,
  parameter int unsigned FIFO_D = dop_pkg::FIFO_DEPTH
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire dop_pkg::dop_vid_in_s vin,
  input  wire logic                vin_valid,
  output logic                     vin_ready,
  output logic [FIFO_W-1:0]        port_data_bus,
  output logic                     port_data_valid,
  input  wire logic                port_data_ready,
  output dop_pkg::dop_pin_out_s    pins
);
  import dop_pkg::*;

  typedef struct packed {
    logic [7:0]   port_ctrl;
    logic [7:0]   ana_ctrl;
    logic [8:0]   gate_start;
    logic [8:0]   gate_stop;
    logic         gate_alt;
    logic [7:0]   hs_begin;
    logic [7:0]   hs_stop;
    logic [1:0]   hs_delay;
    logic         wr_pend;
    logic [7:0]   wr_idx;
    logic [31:0]  rdata;
    logic [10:0]  pix_cnt;
    logic         gate;
    dop_pin_out_s pins;
  } dop_state_s;

  dop_state_s           s, n;
  logic                 acc;
  logic                 keep;
  logic [7:0]           obyte;
  logic [8:0]           conv;
  logic [10:0]          hs_lo, hs_hi, line_eff;
  logic                 fifo_in_ready;
  logic                 push;
  logic [$clog2(FIFO_D):0] fifo_cnt;
  dop_fmt_e             fmt;

  function automatic logic dop_in_win(input logic [10:0] v, input logic [10:0] lo, input logic [10:0] hi);
    return (v >= lo) && (v < hi);
  endfunction

  // timing reference word: 1 F V H P3..P0 with protection bits recomputed
  function automatic logic [7:0] dop_xy_word(input logic f, input logic v, input logic h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction

  function automatic logic [8:0] dop_pick_adc(input dop_vid_in_s d, input logic both);
    if (both) begin
      return d.clock_reference ? d.converter_two : d.converter_one;
    end
    return d.sel_adc2 ? d.converter_two : d.converter_one;
  endfunction

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s.rdata;
  assign pins      = s.pins;
  assign vin_ready = fifo_in_ready;
  assign fmt       = dop_fmt_e'(s.port_ctrl[PC_FMT +: 3]);

  always_comb begin
    n = s;
    acc = hsel && hready && htrans[1];
    // data phase of a write commits this cycle
    if (s.wr_pend) begin
      case (s.wr_idx)
        IDX_PORT_CTRL: n.port_ctrl = hwdata[7:0];
        IDX_ANA_CTRL:  n.ana_ctrl = hwdata[7:0];
        IDX_GATE_CTRL: begin
          n.gate_start = hwdata[GT_START +: 9];
          n.gate_stop  = hwdata[GT_STOP +: 9];
          n.gate_alt   = hwdata[GT_ALT];
        end
        IDX_HSYNC_CTRL: begin
          n.hs_begin = hwdata[HS_BEGIN +: 8];
          n.hs_stop  = hwdata[HS_STOP +: 8];
          n.hs_delay = hwdata[HS_DELAY +: 2];
        end
        default: ;
      endcase
    end
    n.wr_pend = acc && hwrite;
    if (acc) begin
      n.wr_idx = haddr[9:2];
    end
    // read data taken from the updated copy so a read right after a write sees it
    if (acc && !hwrite) begin
      case (haddr[9:2])
        IDX_PORT_CTRL:  n.rdata = {24'h000000, n.port_ctrl};
        IDX_ANA_CTRL:   n.rdata = {24'h000000, n.ana_ctrl};
        IDX_GATE_CTRL:  n.rdata = {n.gate_alt, 6'h00, n.gate_stop, 7'h00, n.gate_start};
        IDX_HSYNC_CTRL: n.rdata = {14'h0000, n.hs_delay, n.hs_stop, n.hs_begin};
        IDX_STATUS:     n.rdata = {16'h0000, 8'(fifo_cnt), 4'h0, vin.horiz_lock_status, vin.field_id, s.gate,
                                   s.pins.lock_ind};
        default:        n.rdata = 32'h00000000;
      endcase
    end

    // horizontal sync window in pixel clocks
    n.pix_cnt = vin.line_start ? 11'h000 : s.pix_cnt + 11'h001;
    hs_lo = 11'(s.hs_begin * HS_WIDTH_STEP) + 11'(s.hs_delay * HS_DELAY_STEP);
    hs_hi = 11'(s.hs_stop * HS_WIDTH_STEP) + 11'(s.hs_delay * HS_DELAY_STEP);
    n.pins.port_horiz_ref_pin = s.port_ctrl[PC_HSEL] ? dop_in_win(s.pix_cnt, hs_lo, hs_hi)
                                                     : vin.horiz_active_reference;

    // gate one line earlier in the second field when the alternative position is set
    line_eff = (s.gate_alt && vin.field_id) ? 11'(vin.line_num) + 11'h001 : 11'(vin.line_num);
    n.gate = dop_in_win(line_eff, 11'(s.gate_start), 11'(s.gate_stop));

    unique case (s.port_ctrl[PC_VSEL +: 2])
      2'h0: n.pins.port_vert_ref_pin = vin.vertical_sync_signal;
      2'h1: n.pins.port_vert_ref_pin = vin.field_id;
      2'h2: n.pins.port_vert_ref_pin = !vin.vertical_sync_signal;
      2'h3: n.pins.port_vert_ref_pin = !vin.field_id;
    endcase
    n.pins.lock_ind = s.port_ctrl[PC_LOCK] ? vin.fast_lock : !vin.horiz_lock_status;
    n.pins.realtime_ctrl_output     = vin.realtime_ctrl_in;
    n.pins.realtime_ctrl_out_enable = s.port_ctrl[PC_RT_EN];
    n.pins.agc_update = s.ana_ctrl[AC_UPDATE] ? vin.field_start : vin.line_start;
    n.pins.analog_test_select = s.ana_ctrl[AC_TEST +: 2];
    n.pins.buffered_crystal_out = vin.crystal_in;
    n.pins.crystal_out_enable = s.ana_ctrl[AC_XTAL];
    n.pins.legacy_status_byte = s.ana_ctrl[AC_LEGACY];
    n.pins.sample_clock_phase = s.ana_ctrl[AC_PHASE +: 2];
    n.pins.reencoder_compat_bit = s.ana_ctrl[AC_COMPAT];

    // output byte formatting
    keep  = 1'b1;
    obyte = vin.pix;
    conv  = dop_pick_adc(vin, vin.both_adc);
    unique case (fmt)
      FMT_656: obyte = vin.pix;
      FMT_GATED: begin
        // field blanking follows the gate through the V bit of the timing word
        if (vin.pix_xy) begin
          obyte = dop_xy_word(vin.pix[6], !s.gate, vin.pix[4]);
        end
      end
      FMT_NOCODE: keep = !vin.pix_code;
      FMT_HIGH: obyte = conv[8:1];
      FMT_LOW: obyte = conv[7:0];
      FMT_SPLIT: begin
        conv  = dop_pick_adc(vin, 1'b0);
        obyte = vin.clock_reference ? conv[8:1] : conv[7:0];
      end
      default: obyte = vin.pix; // reserved codes fall back to the plain stream
    endcase
    push = vin_valid && keep && fifo_in_ready;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.port_ctrl <= RST_PORT_CTRL;
      s.ana_ctrl <= RST_ANA_CTRL;
    end else begin
      s <= n;
    end
  end

  dop_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (FIFO_W'(obyte)),
    .out_valid (port_data_valid),
    .out_ready (port_data_ready),
    .out_data  (port_data_bus),
    .count     (fifo_cnt)
  );

  a_hs_window: assert property (@(posedge hclk) disable iff (!hresetn)
    s.port_ctrl[PC_HSEL] && $stable(s.port_ctrl) |=> pins.port_horiz_ref_pin ==
      (($past(s.pix_cnt) >= $past(hs_lo)) && ($past(s.pix_cnt) < $past(hs_hi))))
    else $error("sync pulse outside its programmed window");
  a_hs_delay_step: assert property (@(posedge hclk) disable iff (!hresetn)
    hs_lo == 11'(s.hs_begin * 8) + 11'(s.hs_delay * 2))
    else $error("sync pulse start not on the programmed step");
  a_vert_select: assert property (@(posedge hclk) disable iff (!hresetn)
    s.port_ctrl[PC_VSEL +: 2] == 2'h2 |=> pins.port_vert_ref_pin == !$past(vin.vertical_sync_signal))
    else $error("inverted vertical sync not on vertical pin");
  a_lock_default: assert property (@(posedge hclk) disable iff (!hresetn)
    !s.port_ctrl[PC_LOCK] |=> pins.lock_ind != $past(vin.horiz_lock_status))
    else $error("lock indicator not inverted lock status");
  a_nocode_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    fmt == FMT_NOCODE && vin.pix_code |-> !push)
    else $error("timing code byte pushed in code-free format");
  a_bypass_high: assert property (@(posedge hclk) disable iff (!hresetn)
    fmt == FMT_HIGH && vin.both_adc && vin.clock_reference |-> obyte == vin.converter_two[8:1])
    else $error("second converter high bits not selected");
  a_split_low: assert property (@(posedge hclk) disable iff (!hresetn)
    fmt == FMT_SPLIT && !vin.clock_reference && !vin.sel_adc2 |-> obyte == vin.converter_one[7:0])
    else $error("low bits not output at reference low");
  a_agc_line: assert property (@(posedge hclk) disable iff (!hresetn)
    !s.ana_ctrl[AC_UPDATE] && vin.line_start |=> pins.agc_update)
    else $error("gain update missed at line start");
  a_xtal_write: assert property (@(posedge hclk) disable iff (!hresetn)
    s.wr_pend && s.wr_idx == IDX_ANA_CTRL |-> ##2 pins.crystal_out_enable == $past(hwdata[3], 2))
    else $error("crystal output enable does not follow write");
  a_gate_alt: assert property (@(posedge hclk) disable iff (!hresetn)
    s.gate_alt && vin.field_id && (11'(vin.line_num) + 11'h001 == 11'(s.gate_start)) &&
      (s.gate_stop > s.gate_start) |=> s.gate)
    else $error("gate not one line earlier in second field");
endmodule // dop_ctrl

// ---- design/dop_pkg.sv ----
/*
  constants, field layouts and carrier structs for the decoder output port control block.
  assumes byte addressing on a 32-bit bus, each register one word at four times its index.
*/
package dop_pkg;
  // register indices; byte address is index * 4
  localparam logic [7:0] IDX_PORT_CTRL  = 8'h13;
  localparam logic [7:0] IDX_ANA_CTRL   = 8'h14;
  localparam logic [7:0] IDX_GATE_CTRL  = 8'h15;
  localparam logic [7:0] IDX_HSYNC_CTRL = 8'h16;
  localparam logic [7:0] IDX_STATUS     = 8'h17;
  localparam logic [7:0] RST_PORT_CTRL  = 8'h00;
  localparam logic [7:0] RST_ANA_CTRL   = 8'h00;
  // port_output_control fields
  localparam int unsigned PC_RT_EN   = 7;
  localparam int unsigned PC_HSEL    = 6;
  localparam int unsigned PC_VSEL    = 4;
  localparam int unsigned PC_LOCK    = 3;
  localparam int unsigned PC_FMT     = 0;
  // analog_converter_compat_control fields
  localparam int unsigned AC_COMPAT  = 7;
  localparam int unsigned AC_UPDATE  = 6;
  localparam int unsigned AC_TEST    = 4;
  localparam int unsigned AC_XTAL    = 3;
  localparam int unsigned AC_LEGACY  = 2;
  localparam int unsigned AC_PHASE   = 0;
  // gate and hsync register fields
  localparam int unsigned GT_START   = 0;
  localparam int unsigned GT_STOP    = 16;
  localparam int unsigned GT_ALT     = 31;
  localparam int unsigned HS_BEGIN   = 0;
  localparam int unsigned HS_STOP    = 8;
  localparam int unsigned HS_DELAY   = 16;
  // pixel-clock steps of the sync pulse
  localparam int unsigned HS_WIDTH_STEP = 8;
  localparam int unsigned HS_DELAY_STEP = 2;
  localparam int unsigned FIFO_WIDTH    = 8;
  localparam int unsigned FIFO_DEPTH    = 16;

  typedef enum logic [2:0] {
    FMT_656 = 3'h0, FMT_GATED = 3'h1, FMT_NOCODE = 3'h2, FMT_RES3 = 3'h3,
    FMT_HIGH = 3'h4, FMT_LOW = 3'h5, FMT_RES6 = 3'h6, FMT_SPLIT = 3'h7
  } dop_fmt_e;

  typedef struct packed {
    logic       line_start;
    logic       field_start;
    logic       horiz_active_reference;
    logic       vertical_sync_signal;
    logic       field_id;
    logic       horiz_lock_status;
    logic       fast_lock;
    logic       crystal_in;
    logic       realtime_ctrl_in;
    logic [8:0] line_num;
    logic [7:0] pix;
    logic       pix_code;
    logic       pix_xy;
    logic       both_adc;
    logic       sel_adc2;
    logic       clock_reference;
    logic [8:0] converter_one;
    logic [8:0] converter_two;
  } dop_vid_in_s;

  typedef struct packed {
    logic       port_horiz_ref_pin;
    logic       port_vert_ref_pin;
    logic       lock_ind;
    logic       agc_update;
    logic       realtime_ctrl_output;
    logic       realtime_ctrl_out_enable;
    logic       buffered_crystal_out;
    logic       crystal_out_enable;
    logic [1:0] analog_test_select;
    logic       legacy_status_byte;
    logic [1:0] sample_clock_phase;
    logic       reencoder_compat_bit;
  } dop_pin_out_s;
endpackage

// ---- tb/dop_rx_model.sv ----
/*
  downstream receiver model that samples the 8-bit output port.
  assumes a byte moves when valid and ready are both high at a rising edge of hclk.
*/
`timescale 1ns/1ps
module dop_rx_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       stall,
  input  wire logic [7:0] port_data_bus,
  input  wire logic       port_data_valid,
  output logic            port_data_ready,
  output logic            got,
  output logic [7:0]      got_byte
);
  // a stalled receiver may hold the port off for as long as it likes
  assign port_data_ready = ~stall;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      got      <= 1'b0;
      got_byte <= 8'h00;
    end else begin
      got      <= port_data_valid & port_data_ready;
      got_byte <= port_data_bus;
    end
  end
endmodule // dop_rx_model

// ---- tb/dop_ctrl_test.sv ----
/*
  self-checking bench for the decoder output port control block.
  assumes zero-wait AHB-Lite slave and a receiver model on the output port.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module dop_ctrl_test;
  import dop_pkg::*;
  localparam logic [31:0] A_PORT = {22'h0, IDX_PORT_CTRL, 2'h0};
  localparam logic [31:0] A_ANA  = {22'h0, IDX_ANA_CTRL, 2'h0};
  logic hclk, hresetn, hsel, hwrite, vin_valid, vin_ready, stall, got, cr, sl;
  logic hreadyout, hresp, port_data_valid, port_data_ready;
  logic [1:0]  htrans;
  logic [2:0]  hsize, f;
  logic [7:0]  port_data_bus, got_byte, ex, pb;
  logic [8:0]  c1, c2;
  logic [31:0] haddr, hwdata, hrdata, d, r;
  dop_vid_in_s  vin;
  dop_pin_out_s pins;
  logic [7:0]  exp_q[$];
  int          err_count, compares, cycles, mode;
  dop_ctrl i_dop_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .vin(vin), .vin_valid(vin_valid), .vin_ready(vin_ready),
    .port_data_bus(port_data_bus), .port_data_valid(port_data_valid),
    .port_data_ready(port_data_ready), .pins(pins));
  dop_rx_model i_dop_rx_model (.hclk(hclk), .hresetn(hresetn), .stall(stall),
    .port_data_bus(port_data_bus), .port_data_valid(port_data_valid),
    .port_data_ready(port_data_ready), .got(got), .got_byte(got_byte));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict;
    end
  end
  always @(posedge hclk) stall <= (mode == 2) ? 1'($urandom) : mode[0];
  // result side: each byte the receiver takes is matched with the oldest note
  always @(negedge hclk) if (got === 1'b1) begin
    ex = exp_q.pop_front();
    `CHK("port byte", ex, got_byte)
  end
  // one AHB single transfer; the wait on hready has no fixed length
  task xfer(input logic we, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    logic rdy;
    begin
      @(posedge hclk);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= we;
      do begin @(negedge hclk); rdy = hreadyout; @(posedge hclk); end while (!rdy);
      htrans <= 2'h0; hwdata <= wd;
      do begin @(negedge hclk); rdy = hreadyout; rd = hrdata; @(posedge hclk); end while (!rdy);
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge hclk);
      @(negedge hclk);
    end
  endtask
  task push(input logic [8:0] a, b, input logic c, s, input logic [7:0] e);
    logic rdy;
    begin
      vin.converter_one <= a; vin.converter_two <= b; vin.clock_reference <= c; vin.sel_adc2 <= s;
      vin_valid <= 1'b1;
      exp_q.push_back(e);
      do begin @(negedge hclk); rdy = vin_ready; @(posedge hclk); end while (!rdy);
    end
  endtask
  function automatic logic [7:0] fmt_byte(input logic [2:0] fm, input logic [8:0] a, b, input logic c, s);
    logic [8:0] v;
    v = (fm == 3'h7) ? (s ? b : a) : (c ? b : a);
    return (fm == 3'h5 || (fm == 3'h7 && !c)) ? v[7:0] : v[8:1];
  endfunction
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = '0; vin = '0; vin_valid = 1'b0; stall = 1'b0; mode = 0;
    void'($urandom(97482));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    `CHK("pins at reset", '0, pins)
    xfer(1'b0, A_PORT, '0, d);
    `CHK("port reg reset", 32'h0, d)
    xfer(1'b0, A_ANA, '0, d);
    `CHK("analog reg reset", 32'h0, d)
    $display("test reset done");
    for (int v = 0; v < 4; v++) begin
      vin <= $bits(dop_vid_in_s)'({$urandom, $urandom});
      xfer(1'b1, A_PORT, {24'h0, v[0], 1'b0, v[1:0], v[0], 3'h0}, d);
      settle;
      `CHK("rt out enable", v[0], pins.realtime_ctrl_out_enable)
      `CHK("agc update", vin.line_start, pins.agc_update)
      `CHK("vert pin", v[1] ^ (v[0] ? vin.field_id : vin.vertical_sync_signal), pins.port_vert_ref_pin)
      `CHK("lock ind", v[0] ? vin.fast_lock : ~vin.horiz_lock_status, pins.lock_ind)
      `CHK("horiz pin", vin.horiz_active_reference, pins.port_horiz_ref_pin)
    end
    $display("test reference pins done");
    repeat (4) begin
      r = $urandom;
      xfer(1'b1, A_ANA, {24'h0, r[7:0]}, d);
      settle;
      `CHK("test select", r[5:4], pins.analog_test_select)
      `CHK("crystal oe", r[3], pins.crystal_out_enable)
      `CHK("status layout", r[2], pins.legacy_status_byte)
      `CHK("sample phase", r[1:0], pins.sample_clock_phase)
      `CHK("compat bit", r[7], pins.reencoder_compat_bit)
    end
    xfer(1'b0, A_ANA, '0, d);
    `CHK("analog readback", {24'h0, r[7:0]}, d)
    xfer(1'b0, 32'h40, '0, d);
    `CHK("unmapped read", 32'h0, d)
    $display("test analog control done");
    // only defined codes are programmed, reserved 011 and 110 never
    for (int k = 0; k < 3; k++) begin
      f = (k == 0) ? 3'h4 : (k == 1) ? 3'h5 : 3'h7;
      xfer(1'b1, A_PORT, {29'h0, f}, d);
      settle;
      mode = (k == 0) ? 1 : 2;
      @(posedge hclk);
      vin.both_adc <= (f != 3'h7);
      for (int n = 0; n < 16; n++) begin
        c1 = 9'($urandom); c2 = 9'($urandom); cr = n[0]; sl = 1'($urandom);
        push(c1, c2, cr, sl, fmt_byte(f, c1, c2, cr, sl));
      end
      if (k == 0) begin
        @(negedge hclk);
        `CHK("fifo full", 1'b0, vin_ready)
        @(posedge hclk);
      end
      vin_valid <= 1'b0;
      mode = 0;
      while (exp_q.size() != 0) @(posedge hclk);
      $display("test format %0h done", f);
    end
    // plain stream keeps every byte, code-free stream drops the timing code bytes
    for (int k = 0; k < 2; k++) begin
      f = (k == 0) ? 3'h0 : 3'h2;
      xfer(1'b1, A_PORT, {29'h0, f}, d);
      settle;
      @(posedge hclk);
      for (int n = 0; n < 12; n++) begin
        pb = 8'($urandom); cr = 1'($urandom);
        vin.pix <= pb; vin.pix_code <= cr; vin.pix_xy <= 1'b0; vin_valid <= 1'b1;
        if (!(cr && f == 3'h2)) exp_q.push_back(pb);
        @(posedge hclk);
      end
      vin_valid <= 1'b0;
      while (exp_q.size() != 0) @(posedge hclk);
      $display("test format %0h done", f);
    end
    give_verdict;
  end
endmodule // dop_ctrl_test
